// ===== hdl/dchsp_host_port.sv
`timescale 1ns/10ps

module dchsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clock_i,    // System clock.
  input  wire logic         rst_i,      // Async reset, high.
  input  wire logic         in_valid_i, // Write request.
  output logic              in_ready_o, // Space available.
  input  wire logic [W-1:0] in_data_i,  // Write data.
  output logic              out_valid_o,// Data available.
  input  wire logic         out_ready_i,// Read accept.
  output logic [W-1:0]      out_data_o  // Head word.
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wptr_q;
  logic [AW:0]  rptr_q;
  logic         full;
  logic         empty;

  assign empty       = (wptr_q == rptr_q);
  assign full        = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge clock_i) begin
    if (in_valid_i && !full) begin
      mem_q[wptr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_q <= '0;
    end else if (in_valid_i && !full) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rptr_q <= '0;
    end else if (out_ready_i && !empty) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule : dchsp_fifo

module dchsp_host_port #(
  parameter logic [7:0] RW_MASK  = dchsp_pkg::RW_OP_MASK,
  parameter logic [7:0] RW_MATCH = dchsp_pkg::RW_OP_MATCH
) (
  input  wire logic                 clock_i,       // System clock.
  input  wire logic                 rst_i,         // Async reset, high.
  input  wire dchsp_pkg::dchsp_bus_t host_i,       // Host strobes and data in.
  output logic [7:0]                data_o,        // Data bus out.
  output logic                      data_oe_o,     // Data bus drive enable.
  output logic                      int_o,         // Execution byte request.
  output dchsp_pkg::dchsp_msr_t     status_o,      // Live status register.
  input  wire logic [3:0]           seek_busy_i,   // Drives seeking.
  input  wire logic                 nondma_i,      // Non-DMA mode.
  output logic                      cmd_valid_o,   // Command byte valid.
  output logic [7:0]                cmd_data_o,    // Command byte.
  input  wire logic                 cmd_ready_i,   // Core takes byte.
  output logic                      cmd_refused_o, // Command refused pulse.
  input  wire logic                 exec_start_i,  // Command phase done.
  input  wire logic                 xfer_req_i,    // Execution byte request.
  input  wire logic                 xfer_dir_i,    // 1: byte to host.
  input  wire logic [7:0]           xfer_rdata_i,  // Byte for host.
  output logic [7:0]                xfer_wdata_o,  // Byte from host.
  output logic                      xfer_done_o,   // Execution byte moved.
  input  wire logic                 res_load_i,    // Result phase start.
  input  wire logic [2:0]           res_count_i,   // Result bytes, 0..4.
  input  wire logic [3:0][7:0]      res_stack_i    // Result bytes.
);
  localparam int SETTLE = (dchsp_pkg::SETTLE_CYC < dchsp_pkg::UPD_MAX_CYC) ?
                          dchsp_pkg::SETTLE_CYC : dchsp_pkg::UPD_MAX_CYC;

  dchsp_pkg::dchsp_phase_t phase_q;
  dchsp_pkg::dchsp_msr_t   msr;
  logic                    rd_act;
  logic                    wr_act;
  logic                    rd_q;
  logic                    wr_q;
  logic                    sel_q;
  logic                    rd_end;
  logic                    wr_end;
  logic                    data_rd_end;
  logic                    data_wr_end;
  logic [7:0]              wdata_q;
  logic [7:0]              xfer_byte_q;
  logic                    xfer_pend_q;
  logic                    xfer_dir_q;
  logic                    busy_q;
  logic                    first_q;
  logic [1:0]              idx_q;
  logic [2:0]              count_q;
  logic [3:0][7:0]         stack_q;
  logic [1:0]              settle_q;
  logic                    ready_ok;
  logic                    dir;
  logic                    fifo_ready;
  logic                    accept_cmd;
  logic                    is_rw;
  logic                    refuse;
  logic                    push;
  logic                    last_res;
  logic                    move_exec;
  logic [7:0]              rd_byte;

  // Only the two legal strobe combinations act.
  assign rd_act = !host_i.cs_n && !host_i.rd_n && host_i.wr_n;
  assign wr_act = !host_i.cs_n && host_i.rd_n && !host_i.wr_n
                  && (host_i.reg_select == dchsp_pkg::SEL_DATA);
  assign rd_end = rd_q && !rd_act;
  assign wr_end = wr_q && !wr_act;
  assign data_rd_end = rd_end && (sel_q == dchsp_pkg::SEL_DATA) && msr.byte_ready;
  assign data_wr_end = wr_end && msr.byte_ready;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      sel_q <= dchsp_pkg::SEL_STATUS;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (rd_act || wr_act) begin
        sel_q <= host_i.reg_select;
      end
    end
  end

  // Write data is taken every cycle of the strobe, so the last strobed value counts.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wdata_q <= dchsp_pkg::DATA_RST;
    end else if (wr_act) begin
      wdata_q <= host_i.data;
    end
  end

  always_comb begin
    ready_ok = 1'b0;
    dir      = dchsp_pkg::DIR_TO_DEV;
    case (phase_q)
      dchsp_pkg::PH_CMD: begin
        ready_ok = fifo_ready;
      end
      dchsp_pkg::PH_EXEC: begin
        ready_ok = nondma_i && xfer_pend_q;
        dir      = xfer_dir_q;
      end
      dchsp_pkg::PH_RESULT: begin
        ready_ok = 1'b1;
        dir      = dchsp_pkg::DIR_TO_HOST;
      end
      default: begin
        ready_ok = 1'b0;
      end
    endcase
  end

  assign msr.drive_seek_busy      = seek_busy_i;
  assign msr.controller_busy      = busy_q;
  assign msr.execution_phase_flag = (phase_q == dchsp_pkg::PH_EXEC) && nondma_i;
  assign msr.transfer_direction   = dir;
  // Ready is held low while the byte settles, never longer than the limit.
  assign msr.byte_ready           = ready_ok && (settle_q == 2'h0);
  assign status_o                 = msr;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= 2'h0;
    end else if ((rd_end && sel_q == dchsp_pkg::SEL_DATA) || wr_end) begin
      settle_q <= 2'(SETTLE);
    end else if (settle_q != 2'h0) begin
      settle_q <= settle_q - 2'h1;
    end
  end

  // Command phase: the first byte is checked before it reaches the core.
  assign accept_cmd = data_wr_end && (phase_q == dchsp_pkg::PH_CMD);
  assign is_rw      = (wdata_q & RW_MASK) == RW_MATCH;
  assign refuse     = accept_cmd && first_q && is_rw
                      && ((|seek_busy_i) || busy_q);
  assign push       = accept_cmd && !refuse;
  assign last_res   = data_rd_end && (phase_q == dchsp_pkg::PH_RESULT)
                      && (({1'b0, idx_q} + 3'h1) >= count_q);
  assign move_exec  = (phase_q == dchsp_pkg::PH_EXEC)
                      && (data_rd_end || data_wr_end);

  dchsp_fifo #(
    .W     (dchsp_pkg::DATA_W),
    .DEPTH (dchsp_pkg::FIFO_DEPTH)
  ) u_cmd_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (wdata_q),
    .out_valid_o (cmd_valid_o),
    .out_ready_i (cmd_ready_i),
    .out_data_o  (cmd_data_o)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_refused_o <= 1'b0;
    end else begin
      cmd_refused_o <= refuse;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      first_q <= 1'b1;
    end else if (phase_q != dchsp_pkg::PH_CMD) begin
      first_q <= 1'b1;
    end else if (push) begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else if (push && first_q && is_rw) begin
      busy_q <= 1'b1;
    end else if (last_res || (res_load_i && res_count_i == 3'h0)) begin
      busy_q <= 1'b0;
    end
  end

  // Phase sequence: command, execution, optional result.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= dchsp_pkg::PH_CMD;
    end else begin
      case (phase_q)
        dchsp_pkg::PH_CMD: begin
          if (exec_start_i) begin
            phase_q <= dchsp_pkg::PH_EXEC;
          end
        end
        dchsp_pkg::PH_EXEC: begin
          if (res_load_i) begin
            phase_q <= (res_count_i == 3'h0) ? dchsp_pkg::PH_CMD : dchsp_pkg::PH_RESULT;
          end
        end
        dchsp_pkg::PH_RESULT: begin
          if (last_res) begin
            phase_q <= dchsp_pkg::PH_CMD;
          end
        end
        default: begin
          phase_q <= dchsp_pkg::PH_CMD;
        end
      endcase
    end
  end

  // Result bytes leave one per read, oldest first.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stack_q <= '0;
      count_q <= 3'h0;
      idx_q   <= 2'h0;
    end else if (res_load_i && phase_q == dchsp_pkg::PH_EXEC) begin
      stack_q <= res_stack_i;
      count_q <= res_count_i;
      idx_q   <= 2'h0;
    end else if (data_rd_end && phase_q == dchsp_pkg::PH_RESULT) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  // A new request in the cycle of a transfer wins over the clear.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_pend_q <= 1'b0;
      xfer_dir_q  <= dchsp_pkg::DIR_TO_DEV;
      xfer_byte_q <= dchsp_pkg::DATA_RST;
    end else if (xfer_req_i && phase_q == dchsp_pkg::PH_EXEC) begin
      xfer_pend_q <= 1'b1;
      xfer_dir_q  <= xfer_dir_i;
      xfer_byte_q <= xfer_rdata_i;
    end else if (move_exec || phase_q != dchsp_pkg::PH_EXEC) begin
      xfer_pend_q <= 1'b0;
    end
  end

  assign int_o = xfer_pend_q && nondma_i && (phase_q == dchsp_pkg::PH_EXEC);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_done_o  <= 1'b0;
      xfer_wdata_o <= dchsp_pkg::DATA_RST;
    end else begin
      xfer_done_o <= move_exec;
      if (move_exec && data_wr_end) begin
        xfer_wdata_o <= wdata_q;
      end
    end
  end

  // Data register view depends on phase; the status view needs no phase.
  always_comb begin
    rd_byte = dchsp_pkg::DATA_RST;
    if (host_i.reg_select == dchsp_pkg::SEL_STATUS) begin
      rd_byte = msr;
    end else if (phase_q == dchsp_pkg::PH_RESULT) begin
      rd_byte = stack_q[idx_q];
    end else if (phase_q == dchsp_pkg::PH_EXEC) begin
      rd_byte = xfer_byte_q;
    end
  end

  // The bus value is refreshed every cycle of the strobe, so status stays live.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= dchsp_pkg::DATA_RST;
    end else if (rd_act) begin
      data_o <= rd_byte;
    end
  end

  assign data_oe_o = rd_act;

endmodule : dchsp_host_port

// ===== hdl/dchsp_pkg.sv
package dchsp_pkg;

  localparam int DATA_W       = 8;
  localparam int NUM_DRIVES   = 4;
  localparam int STACK_DEPTH  = 4;
  localparam int FIFO_DEPTH   = 32;
  localparam int CLK_MHZ      = 100;
  localparam int UPD_MAX_US   = 12;
  // Longest update time in cycles, the exact product of microseconds and MHz.
  localparam int UPD_MAX_CYC  = UPD_MAX_US * CLK_MHZ;
  localparam int SETTLE_CYC   = 2;

  localparam logic       SEL_STATUS  = 1'b0;
  localparam logic       SEL_DATA    = 1'b1;
  localparam logic       DIR_TO_HOST = 1'b1;
  localparam logic       DIR_TO_DEV  = 1'b0;
  localparam logic [7:0] RW_OP_MASK  = 8'h04;
  localparam logic [7:0] RW_OP_MATCH = 8'h04;
  localparam logic [7:0] DATA_RST    = 8'h00;

  typedef enum {
    PH_CMD,
    PH_EXEC,
    PH_RESULT
  } dchsp_phase_t;

  typedef struct packed {
    logic       byte_ready;
    logic       transfer_direction;
    logic       execution_phase_flag;
    logic       controller_busy;
    logic [3:0] drive_seek_busy;
  } dchsp_msr_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       reg_select;
    logic [7:0] data;
  } dchsp_bus_t;

endpackage : dchsp_pkg

// ===== tb/dchsp_host_port_monitor.sv
`timescale 1ns/10ps
module dchsp_host_port_monitor (
  input wire logic                  clock_i,       // Clock.
  input wire logic                  rst_i,         // Reset.
  input wire dchsp_pkg::dchsp_bus_t host_i,        // Host pins.
  input wire logic [7:0]            data_o,        // Bus data.
  input wire logic                  data_oe_o,     // Drive enable.
  input wire logic                  int_o,         // Byte request.
  input wire dchsp_pkg::dchsp_msr_t status_o,      // Status.
  input wire logic [3:0]            seek_busy_i,   // Seeking.
  input wire logic                  nondma_i,      // Non-DMA.
  input wire logic                  cmd_refused_o, // Refusal.
  input wire logic                  xfer_done_o    // Byte moved.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire rd_ok = !host_i.cs_n && !host_i.rd_n && host_i.wr_n;
  property p_oe; data_oe_o == rd_ok; endproperty
  a_oe: assert property (p_oe) else $error("Bad drive enable.");
  property p_msr; rd_ok && !host_i.reg_select |=> data_o == $past(status_o); endproperty
  a_msr: assert property (p_msr) else $error("Status read wrong.");
  property p_seek; status_o.drive_seek_busy == seek_busy_i; endproperty
  a_seek: assert property (p_seek) else $error("Seek bits wrong.");
  property p_exm; status_o.execution_phase_flag |-> nondma_i; endproperty
  a_exm: assert property (p_exm) else $error("Execution flag in DMA.");
  property p_int; int_o |-> status_o.execution_phase_flag && nondma_i; endproperty
  a_int: assert property (p_int) else $error("Stray request.");
  property p_refuse; cmd_refused_o |-> $past(|seek_busy_i) || $past(status_o.controller_busy); endproperty
  a_refuse: assert property (p_refuse) else $error("Needless refusal.");
  property p_settle; $fell(status_o.byte_ready) |=> !status_o.byte_ready; endproperty
  a_settle: assert property (p_settle) else $error("Ready back too soon.");
  property p_busy; $fell(status_o.controller_busy) |-> !status_o.transfer_direction && !status_o.execution_phase_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("Busy cleared off phase.");
  property p_done; xfer_done_o |-> $past(status_o.execution_phase_flag); endproperty
  a_done: assert property (p_done) else $error("Byte moved outside execution.");
endmodule : dchsp_host_port_monitor
bind dchsp_host_port dchsp_host_port_monitor i_mon (.clock_i(clock_i), .rst_i(rst_i), .host_i(host_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .int_o(int_o), .status_o(status_o), .seek_busy_i(seek_busy_i),
  .nondma_i(nondma_i), .cmd_refused_o(cmd_refused_o), .xfer_done_o(xfer_done_o));

// ===== tb/dchsp_host_model.sv
`timescale 1ns/10ps
module dchsp_host_model (
  input  wire logic             clock_i, // Clock.
  output dchsp_pkg::dchsp_bus_t host_o,  // Host pins.
  input  wire logic [7:0]       data_i   // Device data.
);
  initial host_o = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
  // One access of two edges; read data is taken at the last edge.
  task automatic acc(input logic r, input logic w, input logic sel, input logic [7:0] b, output logic [7:0] d);
    @(posedge clock_i);
    #1;
    host_o = '{1'b0, !r, !w, sel, b};
    repeat (2) @(posedge clock_i);
    d = data_i;
    #1;
    host_o = '{1'b1, 1'b1, 1'b1, sel, ~b}; // Released bus no longer shows the byte.
  endtask : acc
  task automatic wait_rdy(input logic dir);
    logic [7:0] s;
    for (int i = 0; i < 4; i++) begin
      repeat (dchsp_pkg::UPD_MAX_CYC) @(posedge clock_i);
      acc(1'b1, 1'b0, dchsp_pkg::SEL_STATUS, 8'h00, s);
      if (s[7] && s[6] == dir) return;
    end
  endtask : wait_rdy
endmodule : dchsp_host_model

// ===== tb/tb_dchsp_host_port.sv
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_dchsp_host_port;
  logic clock_i, rst_i, nondma_i, cmd_ready_i, exec_start_i, xfer_req_i, xfer_dir_i, res_load_i;
  logic data_oe_o, int_o, cmd_valid_o, cmd_refused_o, xfer_done_o;
  logic [7:0] data_o, cmd_data_o, xfer_rdata_i, xfer_wdata_o, d;
  logic [3:0] seek_busy_i;
  logic [2:0] res_count_i;
  logic [3:0][7:0] res_stack_i;
  dchsp_pkg::dchsp_bus_t host;
  dchsp_pkg::dchsp_msr_t status_o;
  int errors, total_checks, ref_seen, done_seen;
  dchsp_host_port i_dut (.clock_i(clock_i), .rst_i(rst_i), .host_i(host), .data_o(data_o),
    .data_oe_o(data_oe_o), .int_o(int_o), .status_o(status_o), .seek_busy_i(seek_busy_i), .nondma_i(nondma_i),
    .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o), .cmd_ready_i(cmd_ready_i), .cmd_refused_o(cmd_refused_o),
    .exec_start_i(exec_start_i), .xfer_req_i(xfer_req_i), .xfer_dir_i(xfer_dir_i), .xfer_rdata_i(xfer_rdata_i),
    .xfer_wdata_o(xfer_wdata_o), .xfer_done_o(xfer_done_o), .res_load_i(res_load_i), .res_count_i(res_count_i),
    .res_stack_i(res_stack_i));
  dchsp_host_model i_host (.clock_i(clock_i), .host_o(host), .data_i(data_o));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (cmd_refused_o === 1'b1) ref_seen++;
    if (xfer_done_o === 1'b1) done_seen++;
  end
  task automatic pulse(ref logic s);
    @(posedge clock_i);
    #1;
    s = 1'b1;
    @(posedge clock_i);
    #1;
    s = 1'b0;
  endtask : pulse
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      seek_busy_i = 4'h1 << i;
      i_host.acc(1'b1, 1'b0, 1'b0, 8'h00, d);
      `CHK(d, {4'h8, 4'h1 << i})
    end
    seek_busy_i = 4'h0;
  endtask : t_status
  task automatic t_illegal();
    i_host.acc(1'b0, 1'b1, 1'b0, 8'h11, d);
    i_host.acc(1'b1, 1'b1, 1'b0, 8'h11, d);
    i_host.acc(1'b1, 1'b1, 1'b1, 8'h11, d);
    // A wrongly taken write would reach the queue one edge after release.
    repeat (2) @(posedge clock_i);
    #1;
    `CHK(cmd_valid_o, 1'b0)
    `CHK(status_o, 8'h80)
  endtask : t_illegal
  task automatic t_refuse();
    seek_busy_i = 4'h2;
    i_host.wait_rdy(1'b0);
    i_host.acc(1'b0, 1'b1, 1'b1, 8'h04, d);
    repeat (4) @(posedge clock_i);
    #1;
    `CHK(ref_seen, 1)
    `CHK(cmd_valid_o, 1'b0)
    seek_busy_i = 4'h0;
  endtask : t_refuse
  task automatic t_fifo();
    logic [7:0] q[3] = '{8'h10, 8'h21, 8'h32};
    foreach (q[i]) begin
      i_host.wait_rdy(1'b0);
      i_host.acc(1'b0, 1'b1, 1'b1, q[i], d);
    end
    repeat (4) @(posedge clock_i);
    foreach (q[i]) begin
      `CHK(cmd_valid_o, 1'b1)
      `CHK(cmd_data_o, q[i])
      @(posedge clock_i);
      #1;
      cmd_ready_i = 1'b1;
      @(posedge clock_i);
      #1;
      cmd_ready_i = 1'b0;
    end
    `CHK(cmd_valid_o, 1'b0)
    res_count_i = 3'd0;
    pulse(exec_start_i);
    pulse(res_load_i);
    repeat (4) @(posedge clock_i);
    `CHK(status_o, 8'h80)
  endtask : t_fifo
  task automatic t_cmd();
    i_host.wait_rdy(1'b0);
    i_host.acc(1'b0, 1'b1, 1'b1, 8'h46, d);
    @(posedge clock_i);
    #1;
    `CHK(status_o.controller_busy, 1'b1)
    pulse(exec_start_i);
    `CHK(status_o.execution_phase_flag, 1'b1)
    xfer_dir_i = 1'b1;
    xfer_rdata_i = 8'hA5;
    pulse(xfer_req_i);
    `CHK(int_o, 1'b1)
    i_host.wait_rdy(1'b1);
    i_host.acc(1'b1, 1'b0, 1'b1, 8'h00, d);
    `CHK(d, 8'hA5)
    xfer_dir_i = 1'b0;
    pulse(xfer_req_i);
    i_host.wait_rdy(1'b0);
    i_host.acc(1'b0, 1'b1, 1'b1, 8'h3C, d);
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(xfer_wdata_o, 8'h3C)
    `CHK(done_seen, 2)
    res_stack_i = 32'h4433_2211;
    res_count_i = 3'd4;
    pulse(res_load_i);
    `CHK(status_o.execution_phase_flag, 1'b0)
    for (int i = 0; i < 4; i++) begin
      i_host.wait_rdy(1'b1);
      i_host.acc(1'b1, 1'b0, 1'b1, 8'h00, d);
      `CHK(d, res_stack_i[i])
    end
    repeat (dchsp_pkg::UPD_MAX_CYC) @(posedge clock_i);
    `CHK(status_o, 8'h80)
  endtask : t_cmd
  // In DMA mode a pending byte must not show as ready, and a data read must move nothing.
  task automatic t_dma();
    #1;
    nondma_i = 1'b0;
    xfer_dir_i = 1'b1;
    pulse(exec_start_i);
    pulse(xfer_req_i);
    `CHK(status_o.execution_phase_flag, 1'b0)
    `CHK(int_o, 1'b0)
    `CHK(status_o.byte_ready, 1'b0)
    i_host.acc(1'b1, 1'b0, 1'b1, 8'h00, d);
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(done_seen, 2)
    res_count_i = 3'h0;
    pulse(res_load_i);
    nondma_i = 1'b1;
    `CHK(status_o, 8'h80)
  endtask : t_dma
  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  initial begin
    // The scenarios need about fifteen thousand cycles; over twice that means a hang.
    repeat (32000) @(posedge clock_i);
    errors++;
    close_out();
  end
  initial begin
    {rst_i, nondma_i} = 2'b11;
    {cmd_ready_i, exec_start_i, xfer_req_i, xfer_dir_i, res_load_i} = 5'h0;
    {seek_busy_i, xfer_rdata_i, res_count_i, res_stack_i} = '0;
    seek_busy_i = 4'h5;
    repeat (12) @(posedge clock_i);
    #1;
    `CHK(status_o, 8'h85)
    rst_i = 1'b0;
    t_status();
    t_illegal();
    t_refuse();
    t_fifo();
    t_cmd();
    t_dma();
    close_out();
  end
endmodule : tb_dchsp_host_port
